// *** core/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLL_FBD = 8'h04;
  localparam logic [7:0] OFS_TRIM = 8'h08;
  localparam logic [7:0] OFS_UNLOCK = 8'h0C;

  // Oscillator control fields
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SW_REQ_BIT = 0;

  localparam int PLL_MULT_W = 9;
  localparam int TRIM_W = 6;
  localparam logic [8:0] PLL_MULT_RESET = 9'h030;
  localparam logic [9:0] PLL_FACTOR_BASE = 10'h002;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // Unlock keys, values arbitrary
  localparam logic [15:0] KEY_HI_A = 16'h00A5;
  localparam logic [15:0] KEY_HI_B = 16'h005A;
  localparam logic [15:0] KEY_LO_A = 16'h00C3;
  localparam logic [15:0] KEY_LO_B = 16'h003C;

  // Source selector codes
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;

  // Oscillator enable bit positions
  localparam int OSC_PRI = 0;
  localparam int OSC_SEC = 1;
  localparam int OSC_FRC = 2;
  localparam int OSC_LOW_POWER_RC_OSC = 3;
  localparam int OSC_PLL = 4;
  localparam int OSC_W = 5;

  localparam logic [3:0] SWITCH_WAIT_TICKS = 4'hA;

  typedef enum {SW_IDLE, SW_WAIT, SW_COUNT} sw_state_type;
  typedef enum {PWR_RUN, PWR_SLEEP, PWR_IDLE} pwr_state_type;

  function automatic logic usesPll(input logic [2:0] src);
    usesPll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction : usesPll

  function automatic logic usesCrystal(input logic [2:0] src);
    usesCrystal = (src == SRC_PRI) || (src == SRC_PRI_PLL);
  endfunction : usesCrystal

  function automatic logic [4:0] srcMask(input logic [2:0] src);
    srcMask = 5'h00;
    case (src)
      SRC_PRI: srcMask[OSC_PRI] = 1'b1;
      SRC_PRI_PLL: srcMask = 5'h11;
      SRC_FRC_PLL: srcMask = 5'h14;
      SRC_SEC: srcMask[OSC_SEC] = 1'b1;
      SRC_LOW_POWER_RC_OSC: srcMask[OSC_LOW_POWER_RC_OSC] = 1'b1;
      default: srcMask[OSC_FRC] = 1'b1;
    endcase
  endfunction : srcMask

endpackage : clk_ctrl_pkg

// *** core/clock_switch_control.sv ***
`timescale 1ns/1ps
module clock_switch_control
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic switchMonitorCfg,
  input wire logic [2:0] initialSourceCfg,
  input wire logic watchdogEnable,
  input wire logic startupTimerDone,
  input wire logic pllLocked,
  input wire logic newClockTick,
  input wire logic oscFail,
  input wire logic powerSaveReq,
  input wire logic powerSaveSleep,
  input wire logic wakeIrq,
  input wire logic watchdogTimeout,
  output logic [2:0] systemSource,
  output logic [clk_ctrl_pkg::OSC_W-1:0] oscEnable,
  output logic [8:0] pllFeedbackMult,
  output logic [9:0] pllFactor,
  output logic [5:0] fastRcTrim,
  output logic startupTimerStart,
  output logic clockFailTrap,
  output logic watchdogClear,
  output logic monitorActive,
  output logic sysClockEn,
  output logic periphClockEn,
  output logic cpuClockEn
);
  import clk_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic initDone_q;
  logic [2:0] curSrc_q;
  logic [2:0] reqSrc_q;
  logic [2:0] targetSrc_q;
  logic swReq_q;
  logic lockFlag_q;
  logic cfFlag_q;
  logic secEn_q;
  logic [8:0] pllMult_q;
  logic [9:0] pllFactor_q;
  logic [5:0] trim_q;
  logic [1:0] keyStage_q;
  logic unlockHi_q;
  logic unlockLo_q;
  logic [3:0] tickCnt_q;
  logic ostNeeded_q;
  logic [OSC_W-1:0] oscEn_q;
  logic [OSC_W-1:0] oscEn_d;
  logic [15:0] rdata_q;
  logic ostStart_q;
  logic trap_q;
  logic wdtClr_q;
  logic wakeHeld_q;
  sw_state_type swState_q;
  pwr_state_type pwrState_q;

  logic switchEn;
  logic inSleep;
  logic failEvt;
  logic hiWr;
  logic loWr;
  logic swStart;
  logic swRedundant;
  logic srcReady;
  logic swDone;
  logic wakeEvt;

  // Config bit high keeps both features off
  assign switchEn = ~switchMonitorCfg;
  assign inSleep = (pwrState_q == PWR_SLEEP);
  // Monitor is blind in Sleep since the clock it watches is off
  assign failEvt = oscFail && switchEn && !inSleep && initDone_q;
  assign hiWr = regWr && (regAddr == OFS_OSC_CTRL) && unlockHi_q;
  assign loWr = regWr && (regAddr == OFS_OSC_CTRL) && unlockLo_q;
  assign swRedundant = (swState_q == SW_IDLE) && swReq_q && switchEn
    && !failEvt && (reqSrc_q == curSrc_q);
  assign swStart = (swState_q == SW_IDLE) && swReq_q && switchEn
    && !failEvt && initDone_q && (reqSrc_q != curSrc_q);
  assign srcReady = (!ostNeeded_q || startupTimerDone)
    && (!usesPll(targetSrc_q) || pllLocked);
  // Sleep freezes the count, so a stray tick must not finish the switch
  assign swDone = (swState_q == SW_COUNT) && newClockTick && !failEvt
    && !inSleep
    && (tickCnt_q == SWITCH_WAIT_TICKS - 4'h1);
  assign wakeEvt = wakeIrq || watchdogTimeout;

  ////////////////////////////////////////////////////////////////////////
  // Unlock keys: each pair arms one byte for the very next write only
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      keyStage_q <= 2'h0;
      unlockHi_q <= 1'b0;
      unlockLo_q <= 1'b0;
    end
    else if (regWr)
    begin
      keyStage_q <= 2'h0;
      unlockHi_q <= 1'b0;
      unlockLo_q <= 1'b0;
      if (regAddr == OFS_UNLOCK)
      begin
        if (regWdata == KEY_HI_A)
          keyStage_q <= 2'h1;
        else if (regWdata == KEY_LO_A)
          keyStage_q <= 2'h2;
        else if (keyStage_q == 2'h1 && regWdata == KEY_HI_B)
          unlockHi_q <= 1'b1;
        else if (keyStage_q == 2'h2 && regWdata == KEY_LO_B)
          unlockLo_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Requested selector, high byte
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reqSrc_q <= SRC_FRC;
    else if (!initDone_q)
      reqSrc_q <= initialSourceCfg;
    else if (hiWr)
      reqSrc_q <= regWdata[REQ_LSB +: 3];
  end

  // Switch request: hardware clear wins, forced low when disabled
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      swReq_q <= 1'b0;
    else if (!switchEn)
      swReq_q <= 1'b0;
    else if (swRedundant || swDone)
      swReq_q <= 1'b0;
    else if (loWr && regWdata[SW_REQ_BIT])
      swReq_q <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      secEn_q <= 1'b0;
    else if (loWr)
      secEn_q <= regWdata[SEC_EN_BIT];
  end

  // Fail flag: failure set beats any clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cfFlag_q <= 1'b0;
    else if (failEvt)
      cfFlag_q <= 1'b1;
    else if (swStart)
      cfFlag_q <= 1'b0;
    else if (loWr && !regWdata[CF_BIT])
      cfFlag_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      lockFlag_q <= 1'b0;
    else if (swStart)
      lockFlag_q <= 1'b0;
    else
      lockFlag_q <= pllLocked && oscEn_q[OSC_PLL];
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pllMult_q <= PLL_MULT_RESET;
      pllFactor_q <= PLL_FACTOR_BASE + {1'b0, PLL_MULT_RESET};
    end
    else
    begin
      if (regWr && regAddr == OFS_PLL_FBD)
        pllMult_q <= regWdata[PLL_MULT_W-1:0];
      pllFactor_q <= PLL_FACTOR_BASE + {1'b0, pllMult_q};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      trim_q <= TRIM_RESET;
    else if (regWr && regAddr == OFS_TRIM)
      trim_q <= regWdata[TRIM_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Current source; strap caught on the first edge after reset release
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      initDone_q <= 1'b0;
      curSrc_q <= SRC_FRC;
    end
    else if (!initDone_q)
    begin
      initDone_q <= 1'b1;
      curSrc_q <= initialSourceCfg;
    end
    else if (failEvt)
      curSrc_q <= usesPll(curSrc_q) ? SRC_FRC_PLL : SRC_FRC;
    else if (swDone)
      curSrc_q <= targetSrc_q;
  end

  // Switch sequencer, SW_WAIT and SW_COUNT frozen in Sleep
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      swState_q <= SW_IDLE;
      targetSrc_q <= SRC_FRC;
      tickCnt_q <= 4'h0;
      ostNeeded_q <= 1'b0;
      ostStart_q <= 1'b0;
    end
    else
    begin
      ostStart_q <= 1'b0;
      case (swState_q)
        SW_IDLE:
        begin
          if (swStart)
          begin
            targetSrc_q <= reqSrc_q;
            tickCnt_q <= 4'h0;
            // Crystal already running needs no new start-up wait
            ostNeeded_q <= usesCrystal(reqSrc_q) && !oscEn_q[OSC_PRI];
            ostStart_q <= usesCrystal(reqSrc_q) && !oscEn_q[OSC_PRI];
            swState_q <= SW_WAIT;
          end
        end
        SW_WAIT:
        begin
          if (failEvt)
            swState_q <= SW_IDLE;
          else if (!inSleep && srcReady)
            swState_q <= SW_COUNT;
        end
        SW_COUNT:
        begin
          if (failEvt || swDone)
            swState_q <= SW_IDLE;
          else if (newClockTick && !inSleep)
            tickCnt_q <= tickCnt_q + 4'h1;
        end
        default: swState_q <= SW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator enables follow the sources in use, so the old one drops
  always_comb
  begin
    oscEn_d = srcMask(curSrc_q);
    if (swState_q != SW_IDLE)
      oscEn_d = oscEn_d | srcMask(targetSrc_q);
    if (secEn_q)
      oscEn_d[OSC_SEC] = 1'b1;
    if (watchdogEnable || switchEn)
      oscEn_d[OSC_LOW_POWER_RC_OSC] = 1'b1;
    if (inSleep)
    begin
      oscEn_d = '0;
      oscEn_d[OSC_SEC] = secEn_q;
      oscEn_d[OSC_LOW_POWER_RC_OSC] = watchdogEnable;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      oscEn_q <= '0;
    else
      oscEn_q <= oscEn_d;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      trap_q <= 1'b0;
    else
      trap_q <= failEvt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-save modes
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pwrState_q <= PWR_RUN;
      wdtClr_q <= 1'b0;
      wakeHeld_q <= 1'b0;
    end
    else
    begin
      wdtClr_q <= 1'b0;
      wakeHeld_q <= 1'b0;
      case (pwrState_q)
        PWR_RUN:
        begin
          if (powerSaveReq)
          begin
            wdtClr_q <= 1'b1;
            wakeHeld_q <= wakeEvt;
            pwrState_q <= powerSaveSleep ? PWR_SLEEP : PWR_IDLE;
          end
        end
        PWR_SLEEP, PWR_IDLE:
        begin
          if (wakeEvt || wakeHeld_q)
            pwrState_q <= PWR_RUN;
        end
        default: pwrState_q <= PWR_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        OFS_OSC_CTRL:
          rdata_q <= {1'b0, curSrc_q, 1'b0, reqSrc_q, 2'b00, lockFlag_q,
            1'b0, cfFlag_q, 1'b0, secEn_q, swReq_q};
        OFS_PLL_FBD: rdata_q <= {7'h00, pllMult_q};
        OFS_TRIM: rdata_q <= {10'h000, trim_q};
        default: rdata_q <= 16'h0000;
      endcase
    end
    else
      rdata_q <= 16'h0000;
  end

  assign regRdata = rdata_q;
  assign systemSource = curSrc_q;
  assign oscEnable = oscEn_q;
  assign pllFeedbackMult = pllMult_q;
  assign pllFactor = pllFactor_q;
  assign fastRcTrim = trim_q;
  assign startupTimerStart = ostStart_q;
  assign clockFailTrap = trap_q;
  assign watchdogClear = wdtClr_q;
  assign monitorActive = switchEn && !inSleep;
  assign sysClockEn = !inSleep;
  assign periphClockEn = !inSleep;
  // Switching never gates the processor
  assign cpuClockEn = (pwrState_q == PWR_RUN);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_redundant_abort: assert property (
    swRedundant |=> !swReq_q && swState_q == SW_IDLE)
    else $error("redundant request not aborted");

  chk_start_clears: assert property (
    swStart |=> !lockFlag_q && (!cfFlag_q || trap_q))
    else $error("switch start left lock or fail flag");

  chk_ten_ticks: assert property (
    swDone |=> curSrc_q == $past(targetSrc_q) && !swReq_q)
    else $error("changeover not taken after ten ticks");

  chk_disabled_request: assert property (
    switchMonitorCfg |=> !swReq_q && swState_q == SW_IDLE)
    else $error("request bit set while switching disabled");

  chk_fail_fallback: assert property (
    failEvt |=> clockFailTrap && cfFlag_q
      && (curSrc_q == SRC_FRC || curSrc_q == SRC_FRC_PLL))
    else $error("failure did not fall back to fast RC");

  chk_fail_pll: assert property (
    failEvt && usesPll(curSrc_q) |=> curSrc_q == SRC_FRC_PLL)
    else $error("PLL failure fallback lost the PLL");

  chk_sleep_entry: assert property (
    pwrState_q == PWR_RUN && powerSaveReq && powerSaveSleep
      |=> !sysClockEn && watchdogClear ##1 !oscEnable[OSC_PRI])
    else $error("Sleep entry did not stop clocks");

  chk_wake_run: assert property (
    pwrState_q != PWR_RUN && wakeEvt |=> cpuClockEn)
    else $error("no wake on interrupt or time-out");

  chk_held_irq: assert property (
    pwrState_q == PWR_RUN && powerSaveReq && wakeIrq
      |=> !cpuClockEn ##1 cpuClockEn)
    else $error("held interrupt did not wake after entry");

  chk_sleep_source: assert property (
    inSleep |=> systemSource == $past(systemSource))
    else $error("source changed during Sleep");

  chk_cpu_switching: assert property (
    swState_q != SW_IDLE && pwrState_q == PWR_RUN |-> cpuClockEn)
    else $error("processor stopped during switch");

endmodule : clock_switch_control

// *** tb/clock_switch_failsafe_power_modes_tb_top.sv ***
`timescale 1ns/1ps
module clock_switch_failsafe_power_modes_tb_top;
  import clk_ctrl_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic switchMonitorCfg = 1'b1;
  logic [2:0] initialSourceCfg = 3'h0;
  logic watchdogEnable = 1'b1;
  logic startupTimerDone = 1'b0;
  logic pllLocked = 1'b0;
  logic newClockTick = 1'b0;
  logic oscFail = 1'b0;
  logic powerSaveReq = 1'b0;
  logic powerSaveSleep = 1'b0;
  logic wakeIrq = 1'b0;
  logic watchdogTimeout = 1'b0;
  logic [2:0] systemSource;
  logic [OSC_W-1:0] oscEnable;
  logic [8:0] pllFeedbackMult;
  logic [9:0] pllFactor;
  logic [5:0] fastRcTrim;
  logic startupTimerStart;
  logic clockFailTrap;
  logic watchdogClear;
  logic monitorActive;
  logic sysClockEn;
  logic periphClockEn;
  logic cpuClockEn;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 89638;
  logic stSeen = 1'b0;
  logic trapSeen = 1'b0;
  logic [15:0] r;
  logic [15:0] d;

  clock_switch_control clock_switch_control_i
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .switchMonitorCfg(switchMonitorCfg),
    .initialSourceCfg(initialSourceCfg),
    .watchdogEnable(watchdogEnable),
    .startupTimerDone(startupTimerDone),
    .pllLocked(pllLocked),
    .newClockTick(newClockTick),
    .oscFail(oscFail),
    .powerSaveReq(powerSaveReq),
    .powerSaveSleep(powerSaveSleep),
    .wakeIrq(wakeIrq),
    .watchdogTimeout(watchdogTimeout),
    .systemSource(systemSource),
    .oscEnable(oscEnable),
    .pllFeedbackMult(pllFeedbackMult),
    .pllFactor(pllFactor),
    .fastRcTrim(fastRcTrim),
    .startupTimerStart(startupTimerStart),
    .clockFailTrap(clockFailTrap),
    .watchdogClear(watchdogClear),
    .monitorActive(monitorActive),
    .sysClockEn(sysClockEn),
    .periphClockEn(periphClockEn),
    .cpuClockEn(cpuClockEn)
  );

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky monitors, pulses are too short to poll from tasks
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (startupTimerStart === 1'b1)
      stSeen <= 1'b1;
    if (clockFailTrap === 1'b1)
      trapSeen <= 1'b1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      results();
    end
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [15:0] factorOf(input logic [15:0] c);
    factorOf = {7'h00, c[8:0]} + 16'h0002;
  endfunction : factorOf

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // Bus tasks start just after an edge and leave strobes low
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd

  task automatic doReset(input logic cfg, input logic [2:0] src);
    rstn <= 1'b0;
    switchMonitorCfg <= cfg;
    initialSourceCfg <= src;
    tick(2);
    rstn <= 1'b1;
    tick(2);
  endtask : doReset

  task automatic doSwitch(input logic [2:0] src);
    wr(OFS_UNLOCK, KEY_HI_A);
    wr(OFS_UNLOCK, KEY_HI_B);
    wr(OFS_OSC_CTRL, {5'h00, src, 8'h00});
    wr(OFS_UNLOCK, KEY_LO_A);
    wr(OFS_UNLOCK, KEY_LO_B);
    wr(OFS_OSC_CTRL, 16'h0009);
    tick(3);
  endtask : doSwitch

  // Clock ticks held high n cycles, each high cycle counts once
  task automatic ticks(input int n);
    newClockTick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    newClockTick <= 1'b0;
    tick(2);
  endtask : ticks

  task automatic powerSave(input logic slp, input logic irq);
    powerSaveReq <= 1'b1;
    powerSaveSleep <= slp;
    wakeIrq <= irq;
    @(posedge ref_clk);
    powerSaveReq <= 1'b0;
    wakeIrq <= 1'b0;
    #1;
  endtask : powerSave

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    doReset(1'b1, SRC_SEC);
    chk("source", 16'h0004, systemSource);
    rd(OFS_PLL_FBD, r);
    chk("pll reset", 16'h0030, r);
    chk("factor reset", 16'd50, pllFactor);
    rd(OFS_TRIM, r);
    chk("trim reset", 16'h0000, r);
    rd(8'h10, r);
    chk("unmapped", 16'h0000, r);
    for (int i = 0; i < 24; i++)
    begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : $random(seed);
      wr(OFS_PLL_FBD, d);
      wr(OFS_TRIM, d);
      rd(OFS_PLL_FBD, r);
      chk("pll", {7'h00, d[8:0]}, r);
      chk("factor", factorOf(d), pllFactor);
      chk("mult out", {7'h00, d[8:0]}, pllFeedbackMult);
      rd(OFS_TRIM, r);
      chk("trim", {10'h000, d[5:0]}, r);
      chk("trim out", d[5:0], fastRcTrim);
    end
    // Disabled: request ignored, monitor off
    chk("mon off", 16'h0000, monitorActive);
    doSwitch(SRC_PRI);
    rd(OFS_OSC_CTRL, r);
    chk("req bit off", 16'h0000, r[0]);
    ticks(12);
    chk("no switch", 16'h0004, systemSource);
    oscFail <= 1'b1;
    tick(1);
    oscFail <= 1'b0;
    tick(2);
    chk("no trap", 16'h0000, trapSeen);
    // Enabled from plain fast RC
    doReset(1'b0, SRC_FRC);
    rd(OFS_OSC_CTRL, r);
    chk("cur code", SRC_FRC, r[14:12]);
    wr(OFS_OSC_CTRL, 16'h0500);
    rd(OFS_OSC_CTRL, r);
    chk("locked write", SRC_FRC, r[10:8]);
    doSwitch(SRC_FRC);
    rd(OFS_OSC_CTRL, r);
    chk("redundant", 16'h0000, r[0]);
    doSwitch(SRC_SEC);
    ticks(9);
    chk("nine ticks", SRC_FRC, systemSource);
    chk("cpu runs", 16'h0001, cpuClockEn);
    ticks(1);
    chk("ten ticks", SRC_SEC, systemSource);
    rd(OFS_OSC_CTRL, r);
    chk("req done", 16'h0000, r[0]);
    chk("cur copied", SRC_SEC, r[14:12]);
    oscFail <= 1'b1;
    tick(1);
    oscFail <= 1'b0;
    chk("trap", 16'h0001, clockFailTrap);
    chk("fallback", SRC_FRC, systemSource);
    rd(OFS_OSC_CTRL, r);
    chk("cf set", 16'h0001, r[3]);
    // Crystal with PLL waits for timer and lock
    doSwitch(SRC_PRI_PLL);
    rd(OFS_OSC_CTRL, r);
    chk("cf cleared", 16'h0000, r[3]);
    chk("lock cleared", 16'h0000, r[5]);
    chk("timer start", 16'h0001, stSeen);
    ticks(12);
    chk("wait ready", SRC_FRC, systemSource);
    startupTimerDone <= 1'b1;
    pllLocked <= 1'b1;
    tick(3);
    ticks(10);
    chk("pll switch", SRC_PRI_PLL, systemSource);
    chk("old off", 16'h0000, oscEnable[OSC_FRC]);
    chk("low_power_rc_osc on", 16'h0001, oscEnable[OSC_LOW_POWER_RC_OSC]);
    rd(OFS_OSC_CTRL, r);
    chk("lock", 16'h0001, r[5]);
    chk("monitor", 16'h0001, monitorActive);
    // Sleep and wake
    powerSave(1'b1, 1'b0);
    chk("cpu sleep", 16'h0000, cpuClockEn);
    chk("sys sleep", 16'h0000, sysClockEn);
    chk("per sleep", 16'h0000, periphClockEn);
    chk("wdt clr", 16'h0001, watchdogClear);
    chk("mon sleep", 16'h0000, monitorActive);
    trapSeen <= 1'b0;
    oscFail <= 1'b1;
    tick(1);
    oscFail <= 1'b0;
    tick(2);
    chk("sleep osc", 16'h0008, oscEnable);
    chk("sleep trap", 16'h0000, trapSeen);
    wakeIrq <= 1'b1;
    tick(1);
    wakeIrq <= 1'b0;
    chk("wake cpu", 16'h0001, cpuClockEn);
    chk("wake src", SRC_PRI_PLL, systemSource);
    // Idle, watchdog wake
    powerSave(1'b0, 1'b0);
    chk("cpu idle", 16'h0000, cpuClockEn);
    chk("sys idle", 16'h0001, sysClockEn);
    chk("per idle", 16'h0001, periphClockEn);
    chk("wdt clr i", 16'h0001, watchdogClear);
    tick(3);
    watchdogTimeout <= 1'b1;
    tick(1);
    watchdogTimeout <= 1'b0;
    chk("wdt wake", 16'h0001, cpuClockEn);
    // Interrupt coincident with entry is held one cycle
    powerSave(1'b0, 1'b1);
    chk("held", 16'h0000, cpuClockEn);
    tick(1);
    chk("held wake", 16'h0001, cpuClockEn);
    oscFail <= 1'b1;
    tick(1);
    oscFail <= 1'b0;
    chk("pll fallback", SRC_FRC_PLL, systemSource);
    results();
  end
endmodule : clock_switch_failsafe_power_modes_tb_top
